// file: rtl/peripheral_register_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "peripheral_register_sync_defs.svh"

module peripheral_register_sync
    import peripheral_register_sync_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              genClk,
    input  wire logic              accValid,
    input  wire logic              accWrite,
    input  wire logic [7:0]        accAddr,
    input  wire logic [DATA_W-1:0] accWdata,
    output logic                   accReady,
    output logic      [DATA_W-1:0] accRdata,
    output logic                   sync_pending_flag,
    output logic                   syncReady,
    output logic                   coreEnable,
    output logic                   coreSwReset,
    output logic      [DATA_W-1:0] coreConfig,
    output logic      [DATA_W-1:0] busConfig,
    input  wire logic [DATA_W-1:0] coreCount
);
    typedef struct packed {
        // bus side
        bus_state_t        bst;
        logic              reqT;
        sync_op_t          op;
        logic              bg;
        logic [DATA_W-1:0] opData;
        logic              wasFlight;
        logic              ctrlEn;
        logic              ctrlSwrst;
        logic              read_continuous_bit;
        logic [7:0]        rrAddr;
        logic [DATA_W-1:0] busCfg;
        logic              haveVal;
        logic [DATA_W-1:0] rdata;
        logic              readyPulse;
        // generic clock side, stepped on rising generic clock edges (genPrev every core cycle)
        logic              genPrev;
        logic              reqS1;
        logic              reqS2;
        logic              reqS3;
        logic              reqS4;
        logic              reqDone;
        logic              ackT;
        logic              en;
        logic              swrstPulse;
        logic [DATA_W-1:0] cfg;
        logic [DATA_W-1:0] capture;
    } state_t;

    state_t r;
    state_t next_r;

    logic genSync;
    logic ackSync;

    sync_stage #(.STAGES(`SYNC_STAGES)) genSyncInst (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (genClk),
        .q        (genSync)
    );

    // acknowledge toggle back to the bus side
    sync_stage #(.STAGES(`SYNC_STAGES)) ackSyncInst (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (r.ackT),
        .q        (ackSync)
    );

    logic inFlight;
    logic ctrlBusy;
    logic done;
    logic genTick;
    logic accept;
    logic startSync;
    logic isRead;
    logic isWrite;

    assign inFlight = r.reqT != ackSync;
    assign ctrlBusy = inFlight && (r.op == OP_EN || r.op == OP_RST);
    assign done     = r.wasFlight && !inFlight;
    assign genTick  = genSync && !r.genPrev;
    assign isRead   = accValid && !accWrite;
    assign isWrite  = accValid && accWrite;

    always_comb begin
        next_r            = r;
        next_r.readyPulse = 1'b0;
        next_r.swrstPulse = 1'b0;
        next_r.wasFlight  = inFlight;
        next_r.genPrev    = genSync;
        accReady          = 1'b1;
        startSync         = 1'b0;

        // ready decision per address and direction
        if (accValid) begin
            case (accAddr)
                `OFS_CTRL: begin
                    if (accWrite) begin
                        accReady = !inFlight;
                    end
                end
                `OFS_READ_REQUEST_REGISTER: begin
                    if (accWrite) begin
                        if (accWdata[`RR_READ_REQUEST_TRIGGER_BIT] || accWdata[`RR_READ_CONTINUOUS_BIT_BIT]) begin
                            accReady = !inFlight;
                        end else begin
                            accReady = !ctrlBusy;
                        end
                    end
                end
                `OFS_BUSREG: begin
                    if (accWrite) begin
                        accReady = !ctrlBusy;
                    end
                end
                `OFS_CFGREG: begin
                    if (accWrite) begin
                        accReady = !inFlight;
                    end else begin
                        accReady = !(inFlight && r.op == OP_WR && !r.bg);
                    end
                end
                `OFS_CNTREG: begin
                    if (!accWrite) begin
                        accReady = r.haveVal ||
                                   (r.bst == B_RDWAIT && done);
                    end
                end
                default: accReady = 1'b1;
            endcase
        end
        accept = accValid && accReady;

        // read data, registered one cycle after acceptance
        if (isRead && accept) begin
            case (accAddr)
                `OFS_CTRL: begin
                    next_r.rdata = '0;
                    next_r.rdata[`CTRL_ENABLE_BIT] = r.ctrlEn;
                    next_r.rdata[`CTRL_SOFTWARE_RESET_BIT_BIT]  = r.ctrlSwrst;
                end
                `OFS_READ_REQUEST_REGISTER: begin
                    next_r.rdata = '0;
                    next_r.rdata[`RR_ADDR_MSB:`RR_ADDR_LSB] = r.rrAddr;
                    next_r.rdata[`RR_READ_CONTINUOUS_BIT_BIT] = r.read_continuous_bit;
                end
                `OFS_BUSREG: next_r.rdata = r.busCfg;
                `OFS_CFGREG: next_r.rdata = r.cfg;
                `OFS_CNTREG: next_r.rdata = r.capture;
                `OFS_STATUS: begin
                    next_r.rdata = '0;
                    next_r.rdata[`STATUS_BUSY_BIT] = sync_pending_flag;
                end
                default: next_r.rdata = '0;
            endcase
        end

        // completion of a transfer
        if (done) begin
            if ((r.op == OP_WR || r.op == OP_RD) && !r.bg) begin
                next_r.readyPulse = 1'b1;
            end
            if (r.op == OP_RD) begin
                next_r.haveVal = r.read_continuous_bit || r.bst != B_RDWAIT;
            end
            if (r.op == OP_RST) begin
                next_r.ctrlSwrst = 1'b0;
                next_r.ctrlEn    = 1'b0;
                next_r.read_continuous_bit     = 1'b0;
                next_r.rrAddr    = '0;
                next_r.busCfg    = `RST_BUSREG;
                next_r.haveVal   = 1'b0;
            end
            if (r.bst == B_RDWAIT) begin
                next_r.bst = B_IDLE;
            end
        end

        // accepted writes; at most one starts a sync
        if (isWrite && accept) begin
            case (accAddr)
                `OFS_CTRL: begin
                    startSync = 1'b1;
                    if (accWdata[`CTRL_SOFTWARE_RESET_BIT_BIT]) begin
                        next_r.op        = OP_RST;
                        next_r.ctrlSwrst = 1'b1;
                    end else begin
                        next_r.op     = OP_EN;
                        next_r.ctrlEn = accWdata[`CTRL_ENABLE_BIT];
                    end
                    next_r.opData = accWdata;
                end
                `OFS_READ_REQUEST_REGISTER: begin
                    next_r.rrAddr = accWdata[`RR_ADDR_MSB:`RR_ADDR_LSB];
                    if (accWdata[`RR_READ_REQUEST_TRIGGER_BIT] || accWdata[`RR_READ_CONTINUOUS_BIT_BIT]) begin
                        startSync      = 1'b1;
                        next_r.op      = OP_RD;
                        next_r.haveVal = 1'b0;
                    end
                end
                `OFS_BUSREG: next_r.busCfg = accWdata;
                `OFS_CFGREG: begin
                    startSync     = 1'b1;
                    next_r.op     = OP_WR;
                    next_r.opData = accWdata;
                end
                default: next_r.busCfg = r.busCfg;
            endcase
        end

        // a read-sync register read with no value on hand
        if (isRead && accAddr == `OFS_CNTREG && !r.haveVal &&
            r.bst == B_IDLE && !inFlight) begin
            startSync = 1'b1;
            next_r.op  = OP_RD;
            next_r.bst = B_RDWAIT;
        end

        if (startSync) begin
            next_r.reqT = ~r.reqT;
            next_r.bg   = 1'b0;
            next_r.read_continuous_bit = isWrite && accAddr == `OFS_READ_REQUEST_REGISTER &&
                           accWdata[`RR_READ_CONTINUOUS_BIT_BIT];
        end else if (r.read_continuous_bit && !inFlight && !done && !accValid &&
                     r.haveVal) begin
            // periodic resync; stalls with the generic clock
            next_r.reqT = ~r.reqT;
            next_r.op   = OP_RD;
            next_r.bg   = 1'b1;
        end

        // generic clock side
        if (genTick) begin
            next_r.reqS1 = r.reqT;
            next_r.reqS2 = r.reqS1;
            // two more generic-clock stages stretch a transfer past four periods
            next_r.reqS3 = r.reqS2;
            next_r.reqS4 = r.reqS3;
            if (r.reqS4 != r.reqDone) begin
                next_r.reqDone = r.reqS4;
                next_r.ackT    = r.reqS4;
                case (r.op)
                    OP_WR:  next_r.cfg = r.opData;
                    OP_EN:  next_r.en  = r.opData[`CTRL_ENABLE_BIT];
                    OP_RST: begin
                        next_r.cfg        = `RST_CFGREG;
                        next_r.en         = 1'b0;
                        next_r.swrstPulse = 1'b1;
                    end
                    OP_RD:  next_r.capture = coreCount;
                    default: next_r.capture = r.capture;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_pending_flag    = inFlight && !r.bg;
    assign syncReady   = r.readyPulse;
    assign accRdata    = r.rdata;
    assign coreEnable  = r.en;
    assign coreSwReset = r.swrstPulse;
    assign coreConfig  = r.cfg;
    assign busConfig   = r.busCfg;
endmodule // peripheral_register_sync

`default_nettype wire

// file: rtl/peripheral_register_sync_defs.svh
`ifndef PERIPHERAL_REGISTER_SYNC_DEFS_SVH
`define PERIPHERAL_REGISTER_SYNC_DEFS_SVH

// register offsets on the access port
`define OFS_CTRL        8'h00
`define OFS_READ_REQUEST_REGISTER     8'h04
`define OFS_BUSREG      8'h08
`define OFS_CFGREG      8'h0c
`define OFS_CNTREG      8'h10
`define OFS_STATUS      8'h14

// control register fields
`define CTRL_SOFTWARE_RESET_BIT_BIT  0
`define CTRL_ENABLE_BIT 1

// read request register fields
`define RR_ADDR_LSB     0
`define RR_ADDR_MSB     7
`define RR_READ_CONTINUOUS_BIT_BIT    14
`define RR_READ_REQUEST_TRIGGER_BIT     15

// status register fields
`define STATUS_BUSY_BIT 0

// reset values
`define RST_CTRL        32'h0000_0000
`define RST_BUSREG      32'h0000_0000
`define RST_CFGREG      32'h0000_0000

// synchroniser depth in flip-flops
`define SYNC_STAGES     2

`endif

// file: rtl/peripheral_register_sync_pkg.sv
package peripheral_register_sync_pkg;

    typedef enum logic [1:0] {
        OP_WR,
        OP_EN,
        OP_RST,
        OP_RD
    } sync_op_t;

    typedef enum logic {
        B_IDLE,
        B_RDWAIT
    } bus_state_t;

endpackage

// file: rtl/sync_stage.sv
`timescale 1ns/10ps
`default_nettype none

module sync_stage #(
    parameter int STAGES = 2
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic [STAGES-1:0] chain;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], d};
        end
    end

    assign q = chain[STAGES-1];
endmodule // sync_stage

`default_nettype wire

// file: sim/core_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_side_model (
    output logic        genClk,
    output logic [31:0] coreCount
);
    // free-running generic clock, three core cycles per period
    initial genClk = 1'b0;
    always #30 genClk = ~genClk;
    initial coreCount = 32'h0000_0000;
    always @(posedge genClk) coreCount <= coreCount + 32'h0000_0001;
endmodule // core_side_model
`default_nettype wire

// file: sim/peripheral_register_sync_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module peripheral_register_sync_asserts #(
    parameter int DATA_W = 32
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              accValid,
    input wire logic              accWrite,
    input wire logic [7:0]        accAddr,
    input wire logic [DATA_W-1:0] accWdata,
    input wire logic              accReady,
    input wire logic [DATA_W-1:0] accRdata,
    input wire logic              sync_pending_flag,
    input wire logic              syncReady,
    input wire logic              coreEnable,
    input wire logic              coreSwReset,
    input wire logic [DATA_W-1:0] busConfig
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wr;
    assign wr = accValid && accReady && accWrite;
    chk_cfg_busy: assert property (wr && accAddr == 8'h0c |=> sync_pending_flag)
        else $error("cfg write without busy");
    chk_cfg_stall: assert property (sync_pending_flag && accValid && accWrite
        && accAddr == 8'h0c |-> !accReady) else $error("cfg write not held");
    chk_bus_read: assert property (accValid && !accWrite
        && (accAddr == 8'h08 || accAddr == 8'h14) |-> accReady)
        else $error("bus read stalled");
    chk_busreg_direct: assert property (wr && accAddr == 8'h08
        |=> busConfig == $past(accWdata)) else $error("busreg not direct");
    chk_busy_bound: assert property ($rose(sync_pending_flag)
        |-> ##[1:80] !sync_pending_flag) else $error("sync too long");
    chk_ready_pulse: assert property (syncReady |=> !syncReady)
        else $error("ready not a pulse");
    chk_enable_sync: assert property (wr && accAddr == 8'h00
        && accWdata[1:0] == 2'b10 |=> sync_pending_flag ##[1:80] coreEnable)
        else $error("enable not synced");
    chk_software_reset_bit_seq: assert property (wr && accAddr == 8'h00
        && accWdata[0] |=> sync_pending_flag ##[0:80] coreSwReset)
        else $error("software_reset_bit not performed");
    chk_rdata_hold: assert property (!(accValid && accReady && !accWrite)
        |=> $stable(accRdata)) else $error("rdata moved");
endmodule // peripheral_register_sync_asserts
bind peripheral_register_sync peripheral_register_sync_asserts #(
    .DATA_W(DATA_W)
) u_chk (
    .core_clk(core_clk), .rst(rst), .accValid(accValid),
    .accWrite(accWrite), .accAddr(accAddr), .accWdata(accWdata),
    .accReady(accReady), .accRdata(accRdata), .sync_pending_flag(sync_pending_flag),
    .syncReady(syncReady), .coreEnable(coreEnable),
    .coreSwReset(coreSwReset), .busConfig(busConfig)
);
`default_nettype wire

// file: sim/tb_peripheral_register_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_register_sync;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        genClk;
    logic        accValid = 1'b0;
    logic        accWrite = 1'b0;
    logic [7:0]  accAddr = 8'h00;
    logic [31:0] accWdata = 32'h0000_0000;
    logic        accReady;
    logic [31:0] accRdata;
    logic        sync_pending_flag;
    logic        syncReady;
    logic        coreEnable;
    logic        coreSwReset;
    logic [31:0] coreConfig;
    logic [31:0] busConfig;
    logic [31:0] coreCount;
    logic [31:0] rd;
    logic [31:0] c0;
    int          st;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          nBusy = 0;
    int          nRdy = 0;
    always #10 core_clk = ~core_clk;
    core_side_model u_core (.genClk(genClk), .coreCount(coreCount));
    peripheral_register_sync u_dut (
        .core_clk(core_clk), .rst(rst), .genClk(genClk),
        .accValid(accValid), .accWrite(accWrite), .accAddr(accAddr),
        .accWdata(accWdata), .accReady(accReady), .accRdata(accRdata),
        .sync_pending_flag(sync_pending_flag), .syncReady(syncReady),
        .coreEnable(coreEnable), .coreSwReset(coreSwReset),
        .coreConfig(coreConfig), .busConfig(busConfig),
        .coreCount(coreCount)
    );
    always @(negedge core_clk) begin
        if (sync_pending_flag === 1'b1) nBusy++;
        if (syncReady === 1'b1) nRdy++;
    end
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access, held until taken; rd and st hold data and stall count
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        accValid <= 1'b1;
        accWrite <= w;
        accAddr <= a;
        accWdata <= d;
        st = 0;
        @(negedge core_clk);
        while (accReady !== 1'b1 && st < 300) begin
            st++;
            @(negedge core_clk);
        end
        if (st >= 300) begin
            n_fail++;
            conclude();
        end
        @(posedge core_clk);
        accValid <= 1'b0;
        @(negedge core_clk);
        rd = accRdata;
        @(posedge core_clk);
    endtask
    task automatic waitIdle;
        int i;
        i = 0;
        @(negedge core_clk);
        while (sync_pending_flag !== 1'b0 && i < 300) begin
            i++;
            @(negedge core_clk);
        end
        if (i >= 300) begin
            n_fail++;
            conclude();
        end
        @(posedge core_clk);
    endtask
    task automatic s_bus_reg;
        acc(1'b1, 8'h08, 32'ha5a5_0001);
        chk("busreg stall", 32'(st), 0);
        chk("busConfig", busConfig, 32'ha5a5_0001);
        acc(1'b0, 8'h08, 32'h0);
        chk("busreg read", rd, 32'ha5a5_0001);
    endtask
    task automatic s_cfg;
        nRdy = 0;
        acc(1'b1, 8'h0c, 32'h0000_1111);
        acc(1'b0, 8'h14, 32'h0);
        chk("busy bit", rd, 32'h1);
        chk("status stall", 32'(st), 0);
        acc(1'b1, 8'h0c, 32'h0000_2222);
        chk("cfg held", 32'(st > 0), 1);
        chk("first cfg", coreConfig, 32'h0000_1111);
        acc(1'b0, 8'h0c, 32'h0);
        chk("cfg read held", 32'(st > 0), 1);
        chk("cfg read", rd, 32'h0000_2222);
        waitIdle();
        chk("second cfg", coreConfig, 32'h0000_2222);
        chk("ready pulses", 32'(nRdy), 2);
    endtask
    task automatic s_cnt;
        c0 = coreCount;
        acc(1'b0, 8'h10, 32'h0);
        chk("cnt stall", 32'(st >= 15), 1);
        chk("cnt value", 32'(rd >= c0 && rd <= coreCount), 1);
        acc(1'b1, 8'h0c, 32'h0000_3333);
        acc(1'b0, 8'h10, 32'h0);
        chk("double stall", 32'(st >= 28), 1);
    endtask
    task automatic s_read_request_trigger;
        acc(1'b1, 8'h04, 32'h0000_8010); // offset
        waitIdle();
        acc(1'b0, 8'h10, 32'h0);
        c0 = rd;
        chk("read_request_trigger stall", 32'(st), 0);
        repeat (20) @(posedge core_clk);
        acc(1'b0, 8'h10, 32'h0);
        chk("read_request_trigger held", rd, c0);
    endtask
    task automatic s_read_continuous_bit;
        acc(1'b1, 8'h04, 32'h0000_4010);
        waitIdle();
        nBusy = 0;
        repeat (40) @(posedge core_clk);
        chk("cont busy", 32'(nBusy), 0);
        c0 = coreCount;
        acc(1'b0, 8'h10, 32'h0);
        chk("cont stall", 32'(st), 0);
        chk("cont fresh", 32'(rd + 32'ha >= c0), 1);
        acc(1'b1, 8'h0c, 32'h0000_5555);
        waitIdle();
        c0 = coreCount;
        repeat (40) @(posedge core_clk);
        acc(1'b0, 8'h10, 32'h0);
        chk("cont stopped", 32'(st > 0 || rd < c0), 1);
    endtask
    task automatic s_enable;
        nRdy = 0;
        acc(1'b1, 8'h00, 32'h0000_0002);
        acc(1'b0, 8'h00, 32'h0);
        chk("enable read", rd, 32'h2);
        chk("ctrl stall", 32'(st), 0);
        acc(1'b1, 8'h08, 32'h0000_0033);
        chk("bus write held", 32'(st > 0), 1);
        chk("core enable", 32'(coreEnable), 1);
        chk("no ready", 32'(nRdy), 0);
    endtask
    task automatic s_software_reset_bit;
        acc(1'b1, 8'h00, 32'h0000_0001);
        acc(1'b0, 8'h00, 32'h0);
        chk("software_reset_bit reads one", rd, 32'h3);
        acc(1'b0, 8'h08, 32'h0);
        chk("bus read stall", 32'(st), 0);
        acc(1'b1, 8'h08, 32'h0000_0044);
        chk("bus write held", 32'(st > 0), 1);
        acc(1'b0, 8'h00, 32'h0);
        chk("ctrl cleared", rd, 32'h0);
        chk("enable cleared", 32'(coreEnable), 0);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        s_bus_reg();
        s_cfg();
        s_cnt();
        s_read_request_trigger();
        s_read_continuous_bit();
        s_enable();
        s_software_reset_bit();
        conclude();
    end
endmodule // tb_peripheral_register_sync
`default_nettype wire
